// ===== rtl/echo_threshold_map_pkg.sv
// Constants and types shared by the echo threshold map register bank
package echo_threshold_map_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int AXI_ADDR_W = 12;
   localparam int DATA_W     = 32;
   localparam int BYTE_W     = 8;
   localparam int WORD_LSB   = 2;
   localparam int IDX_W      = AXI_ADDR_W - WORD_LSB;
   localparam int STRB_W     = DATA_W / 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Register indices; byte address is four times the index
   // ****************************************************************
   localparam logic [IDX_W-1:0] IDX_LEVEL_TWELVE = 10'h06D;
   localparam logic [IDX_W-1:0] IDX_OFFSET       = 10'h06E;
   localparam logic [IDX_W-1:0] IDX_TIMES_A      = 10'h06F;
   localparam logic [IDX_W-1:0] IDX_TIMES_B      = 10'h070;
   localparam logic [IDX_W-1:0] IDX_TIMES_C      = 10'h071;

   // ****************************************************************
   // Field layout
   // ****************************************************************
   localparam int CODE_W      = 4;
   localparam int HI_MSB      = 7;
   localparam int HI_LSB      = 4;
   localparam int LO_MSB      = 3;
   localparam int LO_LSB      = 0;
   localparam int OFF_SIGN    = 3;
   localparam int OFF_VAL_W   = 5;
   localparam int US_W        = 14;
   localparam int TIME_FIELDS = 6;

   localparam logic [CODE_W-1:0] CODE_2000 = 4'h9;
   localparam logic [CODE_W-1:0] CODE_2400 = 4'hA;
   localparam logic [US_W-1:0]   US_2000   = 14'h07D0;
   localparam logic [US_W-1:0]   US_2400   = 14'h0960;
   localparam logic signed [OFF_VAL_W-1:0] OFF_MOST_NEG = 5'sh18;

   // Time code table, code 0 in the lowest slice
   localparam logic [15:0][US_W-1:0] TIME_CODE_US = {
      14'h1F40, 14'h1900, 14'h1450, 14'h0FA0,
      14'h0C80, 14'h0960, 14'h07D0, 14'h0578,
      14'h04B0, 14'h03E8, 14'h0320, 14'h0258,
      14'h0190, 14'h012C, 14'h00C8, 14'h0064};

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_LEVEL_TWELVE,
      SEL_OFFSET,
      SEL_TIMES_A,
      SEL_TIMES_B,
      SEL_TIMES_C
   } sel_e;

endpackage

// ===== rtl/echo_threshold_map_regs.sv
// AXI4-Lite register bank holding part of the two echo threshold presets
`timescale 1ns/1ps
`default_nettype none
module echo_threshold_map_regs (
   input  wire logic                                        aclk,
   input  wire logic                                        aresetn,
   input  wire logic [echo_threshold_map_pkg::AXI_ADDR_W-1:0] awaddr,
   input  wire logic                                        awvalid,
   output logic                                             awready,
   input  wire logic [echo_threshold_map_pkg::DATA_W-1:0]     wdata,
   input  wire logic [echo_threshold_map_pkg::STRB_W-1:0]     wstrb,
   input  wire logic                                        wvalid,
   output logic                                             wready,
   output logic [1:0]                                       bresp,
   output logic                                             bvalid,
   input  wire logic                                        bready,
   input  wire logic [echo_threshold_map_pkg::AXI_ADDR_W-1:0] araddr,
   input  wire logic                                        arvalid,
   output logic                                             arready,
   output logic [echo_threshold_map_pkg::DATA_W-1:0]          rdata,
   output logic [1:0]                                       rresp,
   output logic                                             rvalid,
   input  wire logic                                        rready,
   output logic [echo_threshold_map_pkg::BYTE_W-1:0]          first_preset_level_twelve,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          first_preset_level_offset,
   output logic signed [echo_threshold_map_pkg::OFF_VAL_W-1:0] first_preset_offset_value,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          second_preset_time_one,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          second_preset_time_two,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          second_preset_time_three,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          second_preset_time_four,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          second_preset_time_five,
   output logic [echo_threshold_map_pkg::CODE_W-1:0]          second_preset_time_six,
   output logic [echo_threshold_map_pkg::US_W-1:0]            second_preset_time_one_us,
   output logic [echo_threshold_map_pkg::US_W-1:0]            second_preset_time_two_us,
   output logic [echo_threshold_map_pkg::US_W-1:0]            second_preset_time_three_us,
   output logic [echo_threshold_map_pkg::US_W-1:0]            second_preset_time_four_us,
   output logic [echo_threshold_map_pkg::US_W-1:0]            second_preset_time_five_us,
   output logic [echo_threshold_map_pkg::US_W-1:0]            second_preset_time_six_us
);
   import echo_threshold_map_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic sel_e addr_select(input logic [AXI_ADDR_W-1:0] addr);
      sel_e s;
      s = SEL_NONE;
      case (addr[AXI_ADDR_W-1:WORD_LSB])
         IDX_LEVEL_TWELVE: s = SEL_LEVEL_TWELVE;
         IDX_OFFSET:       s = SEL_OFFSET;
         IDX_TIMES_A:      s = SEL_TIMES_A;
         IDX_TIMES_B:      s = SEL_TIMES_B;
         IDX_TIMES_C:      s = SEL_TIMES_C;
         default:          s = SEL_NONE;
      endcase
      return s;
   endfunction

   // Sign-magnitude; negative zero stands for the most negative value
   function automatic logic signed [OFF_VAL_W-1:0] offset_value(input logic [CODE_W-1:0] f);
      logic [OFF_VAL_W-1:0] mag;
      mag = {2'h0, f[OFF_SIGN-1:0]};
      if (!f[OFF_SIGN]) begin
         return signed'(mag);
      end else if (mag == 5'h00) begin
         return OFF_MOST_NEG;
      end else begin
         return signed'(5'h00 - mag);
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [AXI_ADDR_W-1:0]       aw_addr;
      logic                        aw_got;
      logic [BYTE_W-1:0]           w_byte;
      logic                        w_strb;
      logic                        w_got;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rvalid;
      logic [1:0]                  rresp;
      logic [BYTE_W-1:0]           rdata;
      logic [BYTE_W-1:0]           level_twelve;
      logic [CODE_W-1:0]           offset;
      logic signed [OFF_VAL_W-1:0] off_val;
      logic [BYTE_W-1:0]           times_a;
      logic [BYTE_W-1:0]           times_b;
      logic [BYTE_W-1:0]           times_c;
   } bank_s;

   bank_s bank_reg;
   bank_s bank_next;

   logic                  aw_hs;
   logic                  w_hs;
   logic                  ar_hs;
   logic                  wr_go;
   logic [AXI_ADDR_W-1:0] wr_addr;
   logic [BYTE_W-1:0]     wr_byte;
   logic                  wr_strb;
   sel_e                  wr_sel;
   sel_e                  rd_sel;

   // ****************************************************************
   // Bus handshakes
   // ****************************************************************
   // Address and data are latched separately so either may come first
   assign awready = !bank_reg.aw_got && !bank_reg.bvalid;
   assign wready  = !bank_reg.w_got && !bank_reg.bvalid;
   assign arready = !bank_reg.rvalid;
   assign aw_hs   = awvalid && awready;
   assign w_hs    = wvalid && wready;
   assign ar_hs   = arvalid && arready;
   assign wr_go   = (aw_hs || bank_reg.aw_got) && (w_hs || bank_reg.w_got);
   assign wr_addr = aw_hs ? awaddr : bank_reg.aw_addr;
   assign wr_byte = w_hs ? wdata[BYTE_W-1:0] : bank_reg.w_byte;
   assign wr_strb = w_hs ? wstrb[0] : bank_reg.w_strb;
   assign wr_sel  = addr_select(wr_addr);
   assign rd_sel  = addr_select(araddr);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      bank_next = bank_reg;
      if (aw_hs) begin
         bank_next.aw_addr = awaddr;
         bank_next.aw_got  = 1'b1;
      end
      if (w_hs) begin
         bank_next.w_byte = wdata[BYTE_W-1:0];
         bank_next.w_strb = wstrb[0];
         bank_next.w_got  = 1'b1;
      end
      if (bank_reg.bvalid && bready) begin
         bank_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         bank_next.aw_got = 1'b0;
         bank_next.w_got  = 1'b0;
         bank_next.bvalid = 1'b1;
         bank_next.bresp  = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         // Only byte lane 0 carries a field; a cleared strobe writes nothing
         if (wr_strb) begin
            case (wr_sel)
               SEL_LEVEL_TWELVE: begin
                  bank_next.level_twelve = wr_byte;
               end
               SEL_OFFSET: begin
                  bank_next.offset = wr_byte[LO_MSB:LO_LSB];
               end
               SEL_TIMES_A: begin
                  bank_next.times_a = wr_byte;
               end
               SEL_TIMES_B: begin
                  bank_next.times_b = wr_byte;
               end
               SEL_TIMES_C: begin
                  bank_next.times_c = wr_byte;
               end
               default: begin
                  bank_next.times_c = bank_reg.times_c;
               end
            endcase
         end
      end
      if (bank_reg.rvalid && rready) begin
         bank_next.rvalid = 1'b0;
      end
      if (ar_hs) begin
         bank_next.rvalid = 1'b1;
         bank_next.rresp  = RESP_OKAY;
         case (rd_sel)
            SEL_LEVEL_TWELVE: bank_next.rdata = bank_reg.level_twelve;
            SEL_OFFSET:       bank_next.rdata = {4'h0, bank_reg.offset};
            SEL_TIMES_A:      bank_next.rdata = bank_reg.times_a;
            SEL_TIMES_B:      bank_next.rdata = bank_reg.times_b;
            SEL_TIMES_C:      bank_next.rdata = bank_reg.times_c;
            default: begin
               bank_next.rdata = 8'h00;
               bank_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      bank_next.off_val = offset_value(bank_next.offset);
      if (!aresetn) begin
         // Only bus control is reset; threshold fields keep whatever they hold
         bank_next.aw_got = 1'b0;
         bank_next.w_got  = 1'b0;
         bank_next.bvalid = 1'b0;
         bank_next.bresp  = RESP_OKAY;
         bank_next.rvalid = 1'b0;
         bank_next.rresp  = RESP_OKAY;
         bank_next.rdata  = 8'h00;
      end
   end

   always_ff @(posedge aclk) begin
      bank_reg <= bank_next;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign bvalid = bank_reg.bvalid;
   assign bresp  = bank_reg.bresp;
   assign rvalid = bank_reg.rvalid;
   assign rresp  = bank_reg.rresp;
   assign rdata  = {{(DATA_W-BYTE_W){1'b0}}, bank_reg.rdata};

   assign first_preset_level_twelve = bank_reg.level_twelve;
   assign first_preset_level_offset = bank_reg.offset;
   assign first_preset_offset_value = bank_reg.off_val;
   assign second_preset_time_one    = bank_reg.times_a[HI_MSB:HI_LSB];
   assign second_preset_time_two    = bank_reg.times_a[LO_MSB:LO_LSB];
   assign second_preset_time_three  = bank_reg.times_b[HI_MSB:HI_LSB];
   assign second_preset_time_four   = bank_reg.times_b[LO_MSB:LO_LSB];
   assign second_preset_time_five   = bank_reg.times_c[HI_MSB:HI_LSB];
   assign second_preset_time_six    = bank_reg.times_c[LO_MSB:LO_LSB];

   // ****************************************************************
   // Time code decoding, one shared table for all six segments
   // ****************************************************************
   logic [TIME_FIELDS-1:0][CODE_W-1:0] codes;
   logic [TIME_FIELDS-1:0][US_W-1:0]   times_us;

   assign codes = {second_preset_time_six, second_preset_time_five,
                   second_preset_time_four, second_preset_time_three,
                   second_preset_time_two, second_preset_time_one};

   genvar gi;
   generate
      for (gi = 0; gi < TIME_FIELDS; gi++) begin : g_dec
         time_code_decoder u_dec (
            .aclk    (aclk),
            .code    (codes[gi]),
            .time_us (times_us[gi])
         );
      end
   endgenerate

   assign second_preset_time_one_us   = times_us[0];
   assign second_preset_time_two_us   = times_us[1];
   assign second_preset_time_three_us = times_us[2];
   assign second_preset_time_four_us  = times_us[3];
   assign second_preset_time_five_us  = times_us[4];
   assign second_preset_time_six_us   = times_us[5];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Field checks start at a write: fields power up unknown and stay so through reset
   level_write_a: assert property (wr_go && wr_strb && wr_sel == SEL_LEVEL_TWELVE
      |=> first_preset_level_twelve == $past(wr_byte))
      else $error("level twelve not stored");
   strobe_off_a: assert property (wr_go && !wr_strb && wr_sel == SEL_LEVEL_TWELVE
      |=> first_preset_level_twelve == $past(first_preset_level_twelve))
      else $error("level twelve written with lane off");
   offset_write_a: assert property (wr_go && wr_strb && wr_sel == SEL_OFFSET
      |=> first_preset_level_offset == $past(wr_byte[LO_MSB:LO_LSB]))
      else $error("offset nibble not stored");
   offset_value_a: assert property (wr_go && wr_strb && wr_sel == SEL_OFFSET
      |=> $past(wr_byte[OFF_SIGN]) ? first_preset_offset_value < 0
          : first_preset_offset_value == $signed({2'h0, $past(wr_byte[OFF_SIGN-1:0])}))
      else $error("offset value wrong");
   time_one_a: assert property (wr_go && wr_strb && wr_sel == SEL_TIMES_A
      |=> second_preset_time_one == $past(wr_byte[HI_MSB:HI_LSB])
          && second_preset_time_two == $past(wr_byte[LO_MSB:LO_LSB]))
      else $error("time one or two not stored");
   time_three_a: assert property (wr_go && wr_strb && wr_sel == SEL_TIMES_B
      |=> second_preset_time_three == $past(wr_byte[HI_MSB:HI_LSB])
          && second_preset_time_four == $past(wr_byte[LO_MSB:LO_LSB]))
      else $error("time three or four not stored");
   time_five_a: assert property (wr_go && wr_strb && wr_sel == SEL_TIMES_C
      |=> second_preset_time_five == $past(wr_byte[HI_MSB:HI_LSB])
          && second_preset_time_six == $past(wr_byte[LO_MSB:LO_LSB]))
      else $error("time five or six not stored");
   time_five_us_a: assert property (second_preset_time_five == CODE_2000
      |=> second_preset_time_five_us == US_2000)
      else $error("time five decode wrong");
   time_six_us_a: assert property (second_preset_time_six == CODE_2400
      |=> second_preset_time_six_us == US_2400)
      else $error("time six decode wrong");
   reserved_read_a: assert property (ar_hs && rd_sel == SEL_OFFSET
      |=> rvalid && rdata[HI_MSB:HI_LSB] == 4'h0
          && rdata[LO_MSB:LO_LSB] == $past(first_preset_level_offset))
      else $error("reserved bits not zero");
   level_read_a: assert property (ar_hs && rd_sel == SEL_LEVEL_TWELVE
      |=> rdata[BYTE_W-1:0] == $past(first_preset_level_twelve) && rresp == RESP_OKAY)
      else $error("level twelve read wrong");
   times_read_a: assert property (ar_hs && rd_sel == SEL_TIMES_C
      |=> rdata[HI_MSB:HI_LSB] == $past(second_preset_time_five)
          && rdata[LO_MSB:LO_LSB] == $past(second_preset_time_six))
      else $error("times c read wrong");

   // Bus protocol
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed while waiting");
   unmapped_err_a: assert property (wr_go && wr_sel == SEL_NONE |=> bresp == RESP_SLVERR)
      else $error("unmapped write not flagged");
   unmapped_read_a: assert property (ar_hs && rd_sel == SEL_NONE
      |=> rresp == RESP_SLVERR && rdata == '0)
      else $error("unmapped read not flagged");
   write_answer_a: assert property (wr_go |=> bvalid)
      else $error("write not answered");
   read_answer_a: assert property (ar_hs |=> rvalid)
      else $error("read not answered");
   write_busy_a: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while answer pending");
   read_busy_a: assert property (rvalid |-> !arready)
      else $error("read accepted while answer pending");
   rdata_upper_a: assert property (rvalid |-> rdata[DATA_W-1:BYTE_W] == '0)
      else $error("unused read bits set");
   // Reset is checked with the default disable switched off
   reset_idle_a: assert property (disable iff (1'b0)
      !aresetn |=> !bvalid && !rvalid && awready && wready && arready)
      else $error("bus not idle after reset");

   write_done_c: cover property (wr_go && wr_sel == SEL_TIMES_C ##1 bvalid && bready);
   read_done_c: cover property (ar_hs && rd_sel == SEL_LEVEL_TWELVE ##1 rvalid && rready);
   data_first_c: cover property (w_hs && !aw_hs ##[1:4] aw_hs);
   unmapped_c: cover property (ar_hs && rd_sel == SEL_NONE);
   strobe_off_c: cover property (wr_go && !wr_strb);

endmodule
`default_nettype wire

// ===== rtl/time_code_decoder.sv
// Registered decoder from a 4-bit threshold time code to microseconds
`timescale 1ns/1ps
`default_nettype none
module time_code_decoder (
   input  wire logic                                   aclk,
   input  wire logic [echo_threshold_map_pkg::CODE_W-1:0] code,
   output logic      [echo_threshold_map_pkg::US_W-1:0]   time_us
);
   import echo_threshold_map_pkg::*;

   typedef struct packed {
      logic [US_W-1:0] us;
   } dec_s;

   dec_s dec_reg;
   dec_s dec_next;

   always_comb begin
      dec_next    = dec_reg;
      dec_next.us = TIME_CODE_US[code];
   end

   // Derived value only, so no reset: it follows the code one cycle later
   always_ff @(posedge aclk) begin
      dec_reg <= dec_next;
   end

   assign time_us = dec_reg.us;

endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the echo threshold map register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
   import echo_threshold_map_pkg::*;

   // ****************************************************************
   // Design hookup
   // ****************************************************************
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   logic [AXI_ADDR_W-1:0] awaddr = '0;
   logic                  awvalid = 1'b0;
   logic                  awready;
   logic [DATA_W-1:0]     wdata = '0;
   logic [STRB_W-1:0]     wstrb = '0;
   logic                  wvalid = 1'b0;
   logic                  wready;
   logic [1:0]            bresp;
   logic                  bvalid;
   logic                  bready = 1'b0;
   logic [AXI_ADDR_W-1:0] araddr = '0;
   logic                  arvalid = 1'b0;
   logic                  arready;
   logic [DATA_W-1:0]     rdata;
   logic [1:0]            rresp;
   logic                  rvalid;
   logic                  rready = 1'b0;
   logic [BYTE_W-1:0]     lvl12;
   logic [CODE_W-1:0]     off_code;
   logic signed [OFF_VAL_W-1:0] off_val;
   logic [CODE_W-1:0]     tc [6];
   logic [US_W-1:0]       tu [6];
   int                    miscompares = 0;
   int                    n_tests = 0;

   echo_threshold_map_regs uut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .first_preset_level_twelve(lvl12), .first_preset_level_offset(off_code),
      .first_preset_offset_value(off_val),
      .second_preset_time_one(tc[0]), .second_preset_time_two(tc[1]),
      .second_preset_time_three(tc[2]), .second_preset_time_four(tc[3]),
      .second_preset_time_five(tc[4]), .second_preset_time_six(tc[5]),
      .second_preset_time_one_us(tu[0]), .second_preset_time_two_us(tu[1]),
      .second_preset_time_three_us(tu[2]), .second_preset_time_four_us(tu[3]),
      .second_preset_time_five_us(tu[4]), .second_preset_time_six_us(tu[5]));

   always #20 aclk = ~aclk;

   // ****************************************************************
   // Bus tasks; handshakes sampled mid-cycle so no edge race occurs
   // ****************************************************************
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] resp);
      logic aw_hs, w_hs, b_hs;
      int   n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'hFFFFFF, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      b_hs = 1'b0;
      while (!b_hs && n < 50) begin
         @(negedge aclk);
         aw_hs = awvalid && awready === 1'b1;
         w_hs  = wvalid && wready === 1'b1;
         b_hs  = bvalid === 1'b1;
         resp  = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!b_hs) miscompares++;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic ar_hs, r_hs;
      int   n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      r_hs = 1'b0;
      while (!r_hs && n < 50) begin
         @(negedge aclk);
         ar_hs = arvalid && arready === 1'b1;
         r_hs  = rvalid === 1'b1;
         d     = rdata;
         resp  = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!r_hs) miscompares++;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Ordinary cases: write a byte, read the word back
   // ****************************************************************
   typedef struct { logic [11:0] a; logic [7:0] d; logic [31:0] rb; } row_s;
   row_s rows [5] = '{
      '{{IDX_LEVEL_TWELVE, 2'h0}, 8'hA5, 32'h000000A5},
      '{{IDX_OFFSET, 2'h0},       8'hFB, 32'h0000000B},
      '{{IDX_TIMES_A, 2'h0},      8'h9A, 32'h0000009A},
      '{{IDX_TIMES_B, 2'h0},      8'h0F, 32'h0000000F},
      '{{IDX_TIMES_C, 2'h0},      8'h9A, 32'h0000009A}};
   // Own copy of the time code table, kept apart from the design's
   logic [13:0] us_tab [16] = '{14'h0064, 14'h00C8, 14'h012C, 14'h0190, 14'h0258, 14'h0320,
      14'h03E8, 14'h04B0, 14'h0578, 14'h07D0, 14'h0960, 14'h0C80, 14'h0FA0, 14'h1450,
      14'h1900, 14'h1F40};

   initial begin
      logic [1:0]  r;
      logic [31:0] d;
      logic [3:0]  c;
      logic signed [4:0] e;
      repeat (12) @(posedge aclk);
      `CHK("bvalid_rst", 1'b0, bvalid)
      `CHK("rvalid_rst", 1'b0, rvalid)
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(rows[i].a, rows[i].d, 4'h1, r);
         `CHK("bresp", RESP_OKAY, r)
         rd(rows[i].a, d, r);
         `CHK("rdata", rows[i].rb, d)
         `CHK("rresp", RESP_OKAY, r)
      end
      `CHK("lvl12", 8'hA5, lvl12)
      `CHK("t1", CODE_2000, tc[0])
      `CHK("t2", CODE_2400, tc[1])
      `CHK("t3", 4'h0, tc[2])
      `CHK("t4", 4'hF, tc[3])
      `CHK("t5_us", US_2000, tu[4])
      `CHK("t6_us", US_2400, tu[5])
      $display("test rows done");
      // Every time code in every field, mirrored so each pair differs
      for (int k = 0; k < 16; k++) begin
         c = k[3:0];
         wr({IDX_TIMES_A, 2'h0}, {c, ~c}, 4'h1, r);
         wr({IDX_TIMES_B, 2'h0}, {~c, c}, 4'h1, r);
         wr({IDX_TIMES_C, 2'h0}, {c, ~c}, 4'h1, r);
         @(negedge aclk);
         `CHK("t1_us", us_tab[c], tu[0])
         `CHK("t2_us", us_tab[~c], tu[1])
         `CHK("t3_us", us_tab[~c], tu[2])
         `CHK("t4_us", us_tab[c], tu[3])
         `CHK("t5_us", us_tab[c], tu[4])
         `CHK("t6_us", us_tab[~c], tu[5])
      end
      $display("test time codes done");
      // All offset codes; reserved nibble written with ones each time
      for (int k = 0; k < 16; k++) begin
         c = k[3:0];
         e = c[3] ? ((c[2:0] == 3'h0) ? 5'sh18 : -$signed({2'h0, c[2:0]})) : {2'h0, c[2:0]};
         wr({IDX_OFFSET, 2'h0}, {4'hF, c}, 4'h1, r);
         `CHK("off_code", c, off_code)
         `CHK("off_val", e, off_val)
         rd({IDX_OFFSET, 2'h0}, d, r);
         `CHK("off_rd", {28'h0, c}, d)
      end
      $display("test offset done");
      // Refused accesses: unmapped places and a disabled byte lane
      wr(12'h1C8, 8'h55, 4'h1, r);
      `CHK("unm_bresp", RESP_SLVERR, r)
      rd(12'h000, d, r);
      `CHK("unm_rresp", RESP_SLVERR, r)
      `CHK("unm_rdata", 32'h0, d)
      wr({IDX_LEVEL_TWELVE, 2'h0}, 8'h11, 4'hE, r);
      `CHK("strb_bresp", RESP_OKAY, r)
      rd({IDX_LEVEL_TWELVE, 2'h0}, d, r);
      `CHK("strb_keep", 32'h000000A5, d)
      $display("test refused done");
      // Reset in mid-run must not disturb stored thresholds
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("rvalid_mid", 1'b0, rvalid)
      aresetn <= 1'b1;
      rd({IDX_LEVEL_TWELVE, 2'h0}, d, r);
      `CHK("kept_lvl12", 32'h000000A5, d)
      `CHK("kept_t5", 4'hF, tc[4])
      $display("test mid reset done");
      report_and_stop();
   end

   // Whole run is a few hundred cycles; this limit leaves ample slack
   initial begin
      #(40 * 20000);
      miscompares++;
      report_and_stop();
   end
endmodule
`undef CHK
`default_nettype wire
